// ### hdl/bia_pkg.sv
// constants for the base integer alu datapath
package bia_pkg;
  // opcodes
  localparam logic [6:0] OPC_OP_IMM = 7'h13;
  localparam logic [6:0] OPC_OP     = 7'h33;
  localparam logic [6:0] OPC_LUI    = 7'h37;
  localparam logic [6:0] OPC_AUIPC  = 7'h17;
  // funct3 codes
  localparam logic [2:0] F3_ADD  = 3'h0;
  localparam logic [2:0] F3_SLL  = 3'h1;
  localparam logic [2:0] F3_SLT  = 3'h2;
  localparam logic [2:0] F3_SLTU = 3'h3;
  localparam logic [2:0] F3_XOR  = 3'h4;
  localparam logic [2:0] F3_SR   = 3'h5;
  localparam logic [2:0] F3_OR   = 3'h6;
  localparam logic [2:0] F3_AND  = 3'h7;
  // funct7 codes
  localparam logic [6:0] F7_BASE = 7'h00;
  localparam logic [6:0] F7_ALT  = 7'h20;
  // instruction field positions
  localparam int OPC_LSB    = 0;
  localparam int RD_LSB     = 7;
  localparam int F3_LSB     = 12;
  localparam int RS1_LSB    = 15;
  localparam int RS2_LSB    = 20;
  localparam int F7_LSB     = 25;
  localparam int ALT_BIT    = 30;
  localparam int SIGN_BIT   = 31;
  localparam int SHAMT_W    = 5;
  localparam int IMM_I_W    = 12;
  localparam int UIMM_LSB   = 12;
  localparam int UIMM_W     = 20;
  localparam int REG_IDX_W  = 5;
  // reset values
  localparam logic [4:0] RD_RESET = 5'h00;
endpackage

// ### hdl/bia_alu.sv
// base integer alu datapath: decode, execute, registered result for rd
//
// Overview of operation
// (RQ1) xlen-bit operands in, xlen-bit rd result out
// (RQ2) op-imm is i-type, op is r-type
// (RQ3) no arithmetic exception, ever
// (RQ4) addi adds sign-extended imm, wraps
// (RQ5) slti signed compare writes one or zero
// (RQ6) sltiu sign-extends then compares unsigned
// (RQ7) andi ori xori bitwise with immediate
// (RQ8) immediate shift count from low five bits
// (RQ9) bit 30 picks arithmetic right shift
// (RQ10) zero fill; arithmetic right copies sign
// (RQ11) lui loads upper immediate, low zeros
// (RQ12) auipc adds upper immediate to pc
// (RQ13) r-type uses rs1 rs2 funct7 funct3
// (RQ14) add and sub wrap to xlen
// (RQ15) slt signed, sltu unsigned compare
// (RQ16) register and or xor bitwise
// (RQ17) register shifts use rs2 low five bits
// (RQ18) canonical nop changes no state
// (RQ19) immediates sign-extend from bit 31
// (RQ20) writes to x0 are discarded
// (RQ21) standard base integer encodings
`timescale 1ns/1ps
`default_nettype none
module bia_alu #(
  parameter int XLEN = 32
) (
  // clock and reset
  input  wire logic            i_clock,
  input  wire logic            i_reset,
  // instruction and operands
  input  wire logic            i_valid,
  input  wire logic [31:0]     i_instr,
  input  wire logic [XLEN-1:0] i_rs1_value,
  input  wire logic [XLEN-1:0] i_rs2_value,
  input  wire logic [XLEN-1:0] i_pc,
  // result
  output logic                 o_rd_write,
  output logic [4:0]           o_rd_index,
  output logic [XLEN-1:0]      o_rd_value,
  output logic                 o_illegal
);
  if (XLEN < 32) begin : g_bad_xlen
    $error("bia_alu: XLEN must be at least 32");
  end

  // ----------------------------------------
  // field extraction
  // ----------------------------------------
  wire logic [6:0] opcode = i_instr[bia_pkg::OPC_LSB +: 7];
  wire logic [4:0] rd     = i_instr[bia_pkg::RD_LSB +: bia_pkg::REG_IDX_W];
  wire logic [2:0] funct3 = i_instr[bia_pkg::F3_LSB +: 3];
  wire logic [6:0] funct7 = i_instr[bia_pkg::F7_LSB +: 7];
  wire logic       alt    = i_instr[bia_pkg::ALT_BIT]; // RQ9

  // ----------------------------------------
  // immediates
  // ----------------------------------------
  wire logic            sign  = i_instr[bia_pkg::SIGN_BIT]; // RQ19
  wire logic [XLEN-1:0] imm_i = {{(XLEN-bia_pkg::IMM_I_W){sign}},
                                 i_instr[31:20]}; // RQ19
  wire logic [XLEN-1:0] imm_u = XLEN'($signed({i_instr[31:bia_pkg::UIMM_LSB],
                                               12'h000})); // RQ11 RQ19

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire logic is_imm   = (opcode == bia_pkg::OPC_OP_IMM); // RQ2 RQ21
  wire logic is_reg   = (opcode == bia_pkg::OPC_OP);     // RQ2 RQ21
  wire logic is_lui   = (opcode == bia_pkg::OPC_LUI);
  wire logic is_auipc = (opcode == bia_pkg::OPC_AUIPC);
  wire logic is_shift = (funct3 == bia_pkg::F3_SLL) || (funct3 == bia_pkg::F3_SR);
  // legal funct7: alt only for sub and sra; immediate shifts check imm[11:5]
  wire logic f7_ok_reg = (funct7 == bia_pkg::F7_BASE) ||
                         ((funct7 == bia_pkg::F7_ALT) &&
                          ((funct3 == bia_pkg::F3_ADD) || (funct3 == bia_pkg::F3_SR))); // RQ13
  wire logic f7_ok_imm = !is_shift || (funct7 == bia_pkg::F7_BASE) ||
                         ((funct7 == bia_pkg::F7_ALT) && (funct3 == bia_pkg::F3_SR));
  wire logic legal     = (is_imm && f7_ok_imm) || (is_reg && f7_ok_reg) || is_lui || is_auipc;

  // ----------------------------------------
  // operand b and shift amount
  // ----------------------------------------
  wire logic [XLEN-1:0] opb   = is_reg ? i_rs2_value : imm_i; // RQ13
  wire logic [4:0]      shamt = opb[bia_pkg::SHAMT_W-1:0];    // RQ8 RQ17
  wire logic            do_sub = is_reg && alt && (funct3 == bia_pkg::F3_ADD);

  // ----------------------------------------
  // execute
  // ----------------------------------------
  wire logic [XLEN-1:0] sum     = i_rs1_value + opb;           // RQ4 RQ14 RQ3
  wire logic [XLEN-1:0] diff    = i_rs1_value - opb;           // RQ14 RQ3
  wire logic            lt_s    = $signed(i_rs1_value) < $signed(opb); // RQ5 RQ15
  wire logic            lt_u    = i_rs1_value < opb;           // RQ6 RQ15
  wire logic [XLEN-1:0] sll_v   = i_rs1_value << shamt;        // RQ10
  wire logic [XLEN-1:0] srl_v   = i_rs1_value >> shamt;        // RQ10
  wire logic [XLEN-1:0] sra_v   = XLEN'($signed(i_rs1_value) >>> shamt); // RQ10
  wire logic [XLEN-1:0] auipc_v = i_pc + imm_u;                // RQ12

  logic [XLEN-1:0] op_result;
  always_comb
  begin
    unique case (funct3)
      bia_pkg::F3_ADD:  op_result = do_sub ? diff : sum;
      bia_pkg::F3_SLL:  op_result = sll_v;
      bia_pkg::F3_SLT:  op_result = {{(XLEN-1){1'b0}}, lt_s};
      bia_pkg::F3_SLTU: op_result = {{(XLEN-1){1'b0}}, lt_u};
      bia_pkg::F3_XOR:  op_result = i_rs1_value ^ opb; // RQ7 RQ16
      bia_pkg::F3_SR:   op_result = alt ? sra_v : srl_v; // RQ9
      bia_pkg::F3_OR:   op_result = i_rs1_value | opb; // RQ7 RQ16
      bia_pkg::F3_AND:  op_result = i_rs1_value & opb; // RQ7 RQ16
    endcase
  end

  wire logic [XLEN-1:0] result = is_lui ? imm_u : (is_auipc ? auipc_v : op_result); // RQ11
  // x0 target suppresses write, so nop leaves state alone
  wire logic            wr     = i_valid && legal && (rd != 5'h00); // RQ20 RQ18

  // ----------------------------------------
  // result registers
  // ----------------------------------------
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      o_rd_write <= 1'b0;
      o_rd_index <= bia_pkg::RD_RESET;
      o_rd_value <= '0;
      o_illegal  <= 1'b0;
    end
    else
    begin
      o_rd_write <= wr; // RQ1
      o_rd_index <= rd;
      o_rd_value <= wr ? result : '0;
      o_illegal  <= i_valid && !legal;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_issue_add;
    i_valid && is_imm && funct3 == bia_pkg::F3_ADD && rd != 5'h00;
  endsequence

  property p_addi;
    @(posedge i_clock) disable iff (i_reset)
      s_issue_add |=> o_rd_value == $past(i_rs1_value) + $past(imm_i);
  endproperty
  a_addi: assert property (p_addi) else $error("addi result wrong"); // RQ4

  property p_x0;
    @(posedge i_clock) disable iff (i_reset)
      (i_valid && rd == 5'h00) |=> !o_rd_write;
  endproperty
  a_x0: assert property (p_x0) else $error("write to x0 seen"); // RQ20

  property p_nop;
    @(posedge i_clock) disable iff (i_reset)
      (i_valid && i_instr == 32'h00000013) |=> !o_rd_write && !o_illegal;
  endproperty
  a_nop: assert property (p_nop) else $error("nop changed state"); // RQ18

  property p_lui;
    @(posedge i_clock) disable iff (i_reset)
      (i_valid && is_lui && rd != 5'h00) |=> o_rd_write && o_rd_value[11:0] == 12'h000
        && o_rd_value[31:12] == $past(i_instr[31:12]);
  endproperty
  a_lui: assert property (p_lui) else $error("lui result wrong"); // RQ11

  property p_auipc;
    @(posedge i_clock) disable iff (i_reset)
      (i_valid && is_auipc && rd != 5'h00) |=> o_rd_value == $past(i_pc) + $past(imm_u);
  endproperty
  a_auipc: assert property (p_auipc) else $error("auipc result wrong"); // RQ12

  property p_sub;
    @(posedge i_clock) disable iff (i_reset)
      (i_valid && do_sub && rd != 5'h00) |=> o_rd_value == $past(i_rs1_value) - $past(i_rs2_value);
  endproperty
  a_sub: assert property (p_sub) else $error("sub result wrong"); // RQ14

  property p_sltu;
    @(posedge i_clock) disable iff (i_reset)
      (i_valid && is_reg && funct7 == bia_pkg::F7_BASE && funct3 == bia_pkg::F3_SLTU
        && rd != 5'h00) |=> o_rd_value == XLEN'($past(i_rs1_value) < $past(i_rs2_value));
  endproperty
  a_sltu: assert property (p_sltu) else $error("sltu result wrong"); // RQ15

  property p_srai;
    @(posedge i_clock) disable iff (i_reset)
      (i_valid && is_imm && funct3 == bia_pkg::F3_SR && funct7 == bia_pkg::F7_ALT
        && rd != 5'h00) |=> o_rd_value[XLEN-1] == $past(i_rs1_value[XLEN-1]);
  endproperty
  a_srai: assert property (p_srai) else $error("srai lost sign"); // RQ10

  property p_sll_rs2;
    @(posedge i_clock) disable iff (i_reset)
      (i_valid && is_reg && funct7 == bia_pkg::F7_BASE && funct3 == bia_pkg::F3_SLL
        && rd != 5'h00) |=> o_rd_value == $past(i_rs1_value) << $past(i_rs2_value[4:0]);
  endproperty
  a_sll_rs2: assert property (p_sll_rs2) else $error("sll amount wrong"); // RQ17

  // issue qualifiers for the checks below
  wire logic chk_imm = i_valid && is_imm && (rd != 5'h00);
  wire logic chk_reg = i_valid && is_reg && (rd != 5'h00) && (funct7 == bia_pkg::F7_BASE);
  wire logic chk_alt = i_valid && is_reg && (rd != 5'h00) && (funct7 == bia_pkg::F7_ALT);

  sequence s_issue_slti;
    chk_imm && funct3 == bia_pkg::F3_SLT;
  endsequence
  property p_slti;
    @(posedge i_clock) disable iff (i_reset)
      s_issue_slti |=> o_rd_value == XLEN'($signed($past(i_rs1_value)) < $signed($past(imm_i)));
  endproperty
  a_slti: assert property (p_slti) else $error("slti result wrong"); // RQ5

  sequence s_issue_sltiu;
    chk_imm && funct3 == bia_pkg::F3_SLTU;
  endsequence
  property p_sltiu;
    @(posedge i_clock) disable iff (i_reset)
      s_issue_sltiu |=> o_rd_value == XLEN'($past(i_rs1_value) < $past(imm_i));
  endproperty
  a_sltiu: assert property (p_sltiu) else $error("sltiu result wrong"); // RQ6

  sequence s_issue_andi;
    chk_imm && funct3 == bia_pkg::F3_AND;
  endsequence
  property p_andi;
    @(posedge i_clock) disable iff (i_reset)
      s_issue_andi |=> o_rd_value == ($past(i_rs1_value) & $past(imm_i));
  endproperty
  a_andi: assert property (p_andi) else $error("andi result wrong"); // RQ7

  sequence s_issue_ori;
    chk_imm && funct3 == bia_pkg::F3_OR;
  endsequence
  property p_ori;
    @(posedge i_clock) disable iff (i_reset)
      s_issue_ori |=> o_rd_value == ($past(i_rs1_value) | $past(imm_i));
  endproperty
  a_ori: assert property (p_ori) else $error("ori result wrong"); // RQ7

  sequence s_issue_xori;
    chk_imm && funct3 == bia_pkg::F3_XOR;
  endsequence
  property p_xori;
    @(posedge i_clock) disable iff (i_reset)
      s_issue_xori |=> o_rd_value == ($past(i_rs1_value) ^ $past(imm_i));
  endproperty
  a_xori: assert property (p_xori) else $error("xori result wrong"); // RQ7

  sequence s_issue_slli;
    chk_imm && funct3 == bia_pkg::F3_SLL && funct7 == bia_pkg::F7_BASE;
  endsequence
  property p_slli;
    @(posedge i_clock) disable iff (i_reset)
      s_issue_slli |=> o_rd_value == $past(i_rs1_value) << $past(i_instr[24:20]);
  endproperty
  a_slli: assert property (p_slli) else $error("slli result wrong"); // RQ8

  sequence s_issue_srli;
    chk_imm && funct3 == bia_pkg::F3_SR && funct7 == bia_pkg::F7_BASE;
  endsequence
  property p_srli;
    @(posedge i_clock) disable iff (i_reset)
      s_issue_srli |=> o_rd_value == $past(i_rs1_value) >> $past(i_instr[24:20]);
  endproperty
  a_srli: assert property (p_srli) else $error("srli result wrong"); // RQ10

  sequence s_issue_add_reg;
    chk_reg && funct3 == bia_pkg::F3_ADD;
  endsequence
  property p_add;
    @(posedge i_clock) disable iff (i_reset)
      s_issue_add_reg |=> o_rd_value == $past(i_rs1_value) + $past(i_rs2_value);
  endproperty
  a_add: assert property (p_add) else $error("add result wrong"); // RQ14

  sequence s_issue_slt;
    chk_reg && funct3 == bia_pkg::F3_SLT;
  endsequence
  property p_slt;
    @(posedge i_clock) disable iff (i_reset)
      s_issue_slt |=> o_rd_value == XLEN'($signed($past(i_rs1_value)) < $signed($past(i_rs2_value)));
  endproperty
  a_slt: assert property (p_slt) else $error("slt result wrong"); // RQ15

  sequence s_issue_and;
    chk_reg && funct3 == bia_pkg::F3_AND;
  endsequence
  property p_and;
    @(posedge i_clock) disable iff (i_reset)
      s_issue_and |=> o_rd_value == ($past(i_rs1_value) & $past(i_rs2_value));
  endproperty
  a_and: assert property (p_and) else $error("and result wrong"); // RQ16

  sequence s_issue_or;
    chk_reg && funct3 == bia_pkg::F3_OR;
  endsequence
  property p_or;
    @(posedge i_clock) disable iff (i_reset)
      s_issue_or |=> o_rd_value == ($past(i_rs1_value) | $past(i_rs2_value));
  endproperty
  a_or: assert property (p_or) else $error("or result wrong"); // RQ16

  sequence s_issue_xor;
    chk_reg && funct3 == bia_pkg::F3_XOR;
  endsequence
  property p_xor;
    @(posedge i_clock) disable iff (i_reset)
      s_issue_xor |=> o_rd_value == ($past(i_rs1_value) ^ $past(i_rs2_value));
  endproperty
  a_xor: assert property (p_xor) else $error("xor result wrong"); // RQ16

  sequence s_issue_srl;
    chk_reg && funct3 == bia_pkg::F3_SR;
  endsequence
  property p_srl;
    @(posedge i_clock) disable iff (i_reset)
      s_issue_srl |=> o_rd_value == $past(i_rs1_value) >> $past(i_rs2_value[4:0]);
  endproperty
  a_srl: assert property (p_srl) else $error("srl result wrong"); // RQ17

  sequence s_issue_sra;
    chk_alt && funct3 == bia_pkg::F3_SR;
  endsequence
  property p_sra;
    @(posedge i_clock) disable iff (i_reset)
      s_issue_sra |=> o_rd_value == XLEN'($signed($past(i_rs1_value)) >>> $past(i_rs2_value[4:0]));
  endproperty
  a_sra: assert property (p_sra) else $error("sra result wrong"); // RQ17

  property p_idle;
    @(posedge i_clock) disable iff (i_reset)
      !i_valid |=> !o_rd_write && !o_illegal;
  endproperty
  a_idle: assert property (p_idle) else $error("output without instruction"); // RQ1

  property p_illegal;
    @(posedge i_clock) disable iff (i_reset)
      (i_valid && !(is_imm || is_reg || is_lui || is_auipc)) |=> o_illegal && !o_rd_write;
  endproperty
  a_illegal: assert property (p_illegal) else $error("foreign opcode not flagged"); // RQ21

  property p_rd_index;
    @(posedge i_clock) disable iff (i_reset)
      chk_imm |=> o_rd_write && o_rd_index == $past(rd);
  endproperty
  a_rd_index: assert property (p_rd_index) else $error("rd index wrong"); // RQ1

  property p_x0_value;
    @(posedge i_clock) disable iff (i_reset)
      !o_rd_write |-> o_rd_value == '0;
  endproperty
  a_x0_value: assert property (p_x0_value) else $error("value without write"); // RQ20
endmodule
`default_nettype wire

// ### dv/bia_pipe_model.sv
// pipeline model that feeds instructions and operands to the alu
`timescale 1ns/1ps
`default_nettype none
module bia_pipe_model (
  // instruction and operands
  output logic        o_valid,
  output logic [31:0] o_instr,
  output logic [31:0] o_rs1_value,
  output logic [31:0] o_rs2_value,
  output logic [31:0] o_pc
);
  initial
  begin
    {o_instr, o_rs1_value, o_rs2_value, o_pc} = '0;
    idle();
  end
  // x0 always reads as zero
  task automatic issue(input logic [31:0] ins, a, b, p);
    o_valid = 1'b1;
    o_instr = ins;
    o_rs1_value = (ins[19:15] == 5'h00) ? 32'h0 : a;
    o_rs2_value = (ins[24:20] == 5'h00) ? 32'h0 : b;
    o_pc = p;
  endtask
  // released lines carry no stale value
  task automatic idle();
    o_valid = 1'b0;
    o_instr = ~o_instr;
    o_rs1_value = ~o_rs1_value;
    o_rs2_value = ~o_rs2_value;
    o_pc = ~o_pc;
  endtask
endmodule
`default_nettype wire

// ### dv/bia_alu_test.sv
// self-checking bench for the base integer alu datapath
`timescale 1ns/1ps
`default_nettype none
module bia_alu_test;
  logic        clock;
  logic        reset;
  logic        valid;
  logic [31:0] instr;
  logic [31:0] rs1;
  logic [31:0] rs2;
  logic [31:0] pc;
  logic        rd_write;
  logic [4:0]  rd_index;
  logic [31:0] rd_value;
  logic        illegal;
  int          num_errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  bia_pipe_model i_pipe (.o_valid(valid), .o_instr(instr), .o_rs1_value(rs1),
    .o_rs2_value(rs2), .o_pc(pc));
  bia_alu #(.XLEN(32)) i_dut (.i_clock(clock), .i_reset(reset), .i_valid(valid),
    .i_instr(instr), .i_rs1_value(rs1), .i_rs2_value(rs2), .i_pc(pc), .o_rd_write(rd_write),
    .o_rd_index(rd_index), .o_rd_value(rd_value), .o_illegal(illegal));
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      num_errors++;
      test_done();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [31:0] ityp(input logic [11:0] imm, input logic [2:0] f3,
    input logic [4:0] rd = 5'h01);
    return {imm, 5'h02, f3, rd, bia_pkg::OPC_OP_IMM};
  endfunction
  function automatic logic [31:0] rtyp(input logic [6:0] f7, input logic [2:0] f3);
    return {f7, 5'h03, 5'h02, f3, 5'h01, bia_pkg::OPC_OP};
  endfunction
  // issue at falling edge, judge the registered answer one cycle later
  task automatic run(input logic [31:0] ins, a, b, exp, p = 0,
    input logic wr = 1'b1, ill = 1'b0);
    i_pipe.issue(ins, a, b, p);
    @(negedge clock);
    check(rd_write, wr);
    check(illegal, ill);
    check(rd_value, exp);
    if (wr)
      check(rd_index, ins[11:7]);
  endtask
  // ----------------------------------------
  // scenarios, issued back to back
  // ----------------------------------------
  task automatic t_imm();
    run(ityp(12'h001, bia_pkg::F3_ADD), 32'h7FFFFFFF, 0, 32'h80000000);
    run(ityp(12'h001, bia_pkg::F3_SLT), 32'hFFFFFFFE, 0, 32'h1);
    run(ityp(12'hFFF, bia_pkg::F3_SLTU), 32'h1000, 0, 32'h1);
    run(ityp(12'hF0F, bia_pkg::F3_AND), 32'h12345678, 0, 32'h12345608);
    run(ityp(12'h800, bia_pkg::F3_OR), 32'h1, 0, 32'hFFFFF801);
    run(ityp(12'hFFF, bia_pkg::F3_XOR), 32'h12345678, 0, 32'hEDCBA987);
  endtask
  task automatic t_shift();
    run(ityp(12'h01F, bia_pkg::F3_SLL), 32'h3, 0, 32'h80000000);
    run(ityp(12'h004, bia_pkg::F3_SR), 32'h80000010, 0, 32'h08000001);
    run(ityp(12'h404, bia_pkg::F3_SR), 32'h80000010, 0, 32'hF8000001);
  endtask
  task automatic t_upper();
    run({20'hFFFFF, 5'h01, bia_pkg::OPC_LUI}, 0, 0, 32'hFFFFF000);
    run({20'h80000, 5'h01, bia_pkg::OPC_AUIPC}, 0, 0, 32'h1004, 32'h80001004);
  endtask
  task automatic t_reg();
    run(rtyp(bia_pkg::F7_BASE, bia_pkg::F3_ADD), 32'hFFFFFFFF, 32'h2, 32'h1);
    run(rtyp(bia_pkg::F7_ALT, bia_pkg::F3_ADD), 32'h1, 32'h2, 32'hFFFFFFFF);
    run(rtyp(bia_pkg::F7_BASE, bia_pkg::F3_SLT), 32'hFFFFFFFF, 32'h1, 32'h1);
    run(rtyp(bia_pkg::F7_BASE, bia_pkg::F3_SLTU), 32'hFFFFFFFF, 32'h1, 0);
    run(rtyp(bia_pkg::F7_BASE, bia_pkg::F3_AND), 32'hFF00FF00, 32'h0FF00FF0, 32'h0F000F00);
    run(rtyp(bia_pkg::F7_BASE, bia_pkg::F3_OR), 32'hFF00FF00, 32'h0FF00FF0, 32'hFFF0FFF0);
    run(rtyp(bia_pkg::F7_BASE, bia_pkg::F3_XOR), 32'hFF00FF00, 32'h0FF00FF0, 32'hF0F0F0F0);
    run(rtyp(bia_pkg::F7_BASE, bia_pkg::F3_SLL), 32'h1, 32'hFFFFFFE4, 32'h10);
    run(rtyp(bia_pkg::F7_BASE, bia_pkg::F3_SR), 32'h80000000, 32'hFFFFFFE4, 32'h08000000);
    run(rtyp(bia_pkg::F7_ALT, bia_pkg::F3_SR), 32'h80000000, 32'hFFFFFFE4, 32'hF8000000);
  endtask
  task automatic t_x0();
    run({25'h0, bia_pkg::OPC_OP_IMM}, 32'h5, 0, 0, 0, 1'b0);
    run(ityp(12'h005, bia_pkg::F3_ADD, 5'h00), 32'h5, 0, 0, 0, 1'b0);
    run(32'h0000007F, 32'h5, 0, 0, 0, 1'b0, 1'b1);
    run(rtyp(7'h01, bia_pkg::F3_ADD), 32'h5, 32'h1, 0, 0, 1'b0, 1'b1);
  endtask
  initial
  begin
    reset = 1'b1;
    repeat (20) @(negedge clock);
    reset = 1'b0;
    check(rd_value, 0);
    t_imm();
    t_shift();
    t_upper();
    t_reg();
    t_x0();
    i_pipe.idle();
    @(negedge clock);
    check(rd_write, 0);
    test_done();
  end
endmodule
`default_nettype wire
